// >>> core/port_control_line_interrupt_logic.sv
// Control registers, interrupt flags and control lines of a two-port adapter
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defs.svh"

// Behaviour
// - Bit5 low: second line input, bit3/bit4
// - Control word fields: flags, aux, dir, first
// - First line edge by bit1, enable bit0
// - Data register read clears first flag
// - Late enable still raises pending request
// - Second line edge by bit4, enable bit3
// - Data register read clears second flag
// - Late bit3 enable raises pending request
// - Bit5 high: second line driven output
// - B handshake: high on first flag set
// - B low at enable rise after write
// - B pulse: high after deselected enable
// - B level mode follows control bit3
// - A handshake: high on first flag set
// - A low at enable fall of read
// - A pulse: high at deselected enable fall
// - A level mode copies control bit3
// - Selects pick data/direction or control
// - Reset clears all, lines input, irq off
// - Flag bits read-only, bits 0-5 writable
module port_control_line_interrupt_logic
  import port_ctrl_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   bus_enable_pulse,
  input  wire logic                   chip_select,
  input  wire logic                   read_not_write,
  input  wire logic                   reg_select_low,
  input  wire logic                   reg_select_high,
  input  wire logic [`DATA_WIDTH-1:0] bus_write_data,
  output logic      [`DATA_WIDTH-1:0] bus_read_data,
  output logic                        bus_read_oe,
  input  wire logic                   a_edge_input,
  input  wire logic                   b_edge_input,
  input  wire logic                   a_aux_line_in,
  output logic                        a_aux_line_out,
  output logic                        a_aux_line_oe,
  input  wire logic                   b_aux_line_in,
  output logic                        b_aux_line_out,
  output logic                        b_aux_line_oe,
  output logic                        a_int_request_n_out,
  output logic                        a_int_request_n_oe,
  output logic                        b_int_request_n_out,
  output logic                        b_int_request_n_oe,
  input  wire logic [`DATA_WIDTH-1:0] a_data_rdata,
  input  wire logic [`DATA_WIDTH-1:0] a_direction_rdata,
  input  wire logic [`DATA_WIDTH-1:0] b_data_rdata,
  input  wire logic [`DATA_WIDTH-1:0] b_direction_rdata,
  output logic      [`DATA_WIDTH-1:0] port_write_data,
  output logic                        a_data_read_strobe,
  output logic                        a_data_write_strobe,
  output logic                        a_direction_write_strobe,
  output logic                        b_data_read_strobe,
  output logic                        b_data_write_strobe,
  output logic                        b_direction_write_strobe
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [`BUS_PIN_WIDTH-1:0]  bus_level;
  logic [`BUS_PIN_WIDTH-1:0]  bus_rise;
  logic [`BUS_PIN_WIDTH-1:0]  bus_fall;
  logic [`LINE_PIN_WIDTH-1:0] line_level;
  logic [`LINE_PIN_WIDTH-1:0] line_rise;
  logic [`LINE_PIN_WIDTH-1:0] line_fall;

  // Bus fields are stable across the enable pulse, so skew is harmless
  pin_sync #(.WIDTH(`BUS_PIN_WIDTH)) bus_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  ({bus_write_data, reg_select_high, reg_select_low,
               read_not_write, chip_select, bus_enable_pulse}),
    .level   (bus_level),
    .rise    (bus_rise),
    .fall    (bus_fall)
  );

  // Edge detection needs one clock between edges; the bus side
  // guarantees a whole enable pulse of settling
  pin_sync #(.WIDTH(`LINE_PIN_WIDTH)) line_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  ({b_aux_line_in, a_aux_line_in, b_edge_input, a_edge_input}),
    .level   (line_level),
    .rise    (line_rise),
    .fall    (line_fall)
  );

  // ************************************************************
  // Bus cycle decode
  // ************************************************************
  wire                   enable_rise = bus_rise[0];
  wire                   enable_fall = bus_fall[0];
  wire                   selected    = bus_level[1];
  wire                   is_read     = bus_level[2];
  wire [1:0]             reg_select  = bus_level[4:3];
  wire [`DATA_WIDTH-1:0] write_data  = bus_level[12:5];

  logic       cycle_selected;
  logic       cycle_read;
  logic [1:0] cycle_select;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cycle_selected <= 1'b0;
      cycle_read     <= 1'b0;
      cycle_select   <= `SEL_A_DATA;
    end else if (enable_rise) begin
      cycle_selected <= selected;
      cycle_read     <= is_read;
      cycle_select   <= reg_select;
    end
  end

  logic [`CTRL_RW_WIDTH-1:0] port_a_control;
  logic [`CTRL_RW_WIDTH-1:0] port_b_control;

  wire a_data_view = port_a_control[`DIR_ACCESS_BIT];
  wire b_data_view = port_b_control[`DIR_ACCESS_BIT];

  // Actions complete at the falling edge of a selected enable pulse
  wire end_selected   = enable_fall & cycle_selected;
  wire end_deselected = enable_fall & ~cycle_selected;
  wire end_read       = end_selected & cycle_read;
  wire end_write      = end_selected & ~cycle_read;

  wire hit_a_data = (cycle_select == `SEL_A_DATA);
  wire hit_a_ctrl = (cycle_select == `SEL_A_CTRL);
  wire hit_b_data = (cycle_select == `SEL_B_DATA);
  wire hit_b_ctrl = (cycle_select == `SEL_B_CTRL);

  wire a_data_read  = end_read & hit_a_data & a_data_view;
  wire b_data_read  = end_read & hit_b_data & b_data_view;
  wire a_ctrl_write = end_write & hit_a_ctrl;
  wire b_ctrl_write = end_write & hit_b_ctrl;

  assign a_data_read_strobe       = a_data_read;
  assign b_data_read_strobe       = b_data_read;
  assign a_data_write_strobe      = end_write & hit_a_data & a_data_view;
  assign a_direction_write_strobe = end_write & hit_a_data & ~a_data_view;
  assign b_data_write_strobe      = end_write & hit_b_data & b_data_view;
  assign b_direction_write_strobe = end_write & hit_b_data & ~b_data_view;

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_a_control  <= `CTRL_RESET;
      port_b_control  <= `CTRL_RESET;
      port_write_data <= `DATA_RESET;
    end else begin
      if (end_write) begin
        port_write_data <= write_data;
      end
      if (a_ctrl_write) begin
        port_a_control <= write_data[`CTRL_RW_WIDTH-1:0];
      end
      if (b_ctrl_write) begin
        port_b_control <= write_data[`CTRL_RW_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // Interrupt flags
  // ************************************************************
  logic a_first_flag;
  logic a_second_flag;
  logic b_first_flag;
  logic b_second_flag;

  wire a_first_set = port_a_control[`FIRST_EDGE_BIT] ?
                     line_rise[0] : line_fall[0];
  wire b_first_set = port_b_control[`FIRST_EDGE_BIT] ?
                     line_rise[1] : line_fall[1];

  // Second line only raises its flag while it is an input
  wire a_second_set = ~port_a_control[`AUX_OUTPUT_BIT] &
                      (port_a_control[`AUX_CTRL4_BIT] ?
                       line_rise[2] : line_fall[2]);
  wire b_second_set = ~port_b_control[`AUX_OUTPUT_BIT] &
                      (port_b_control[`AUX_CTRL4_BIT] ?
                       line_rise[3] : line_fall[3]);

  event_flag a_first_cell (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .set_event   (a_first_set),
    .clear_event (a_data_read),
    .flag        (a_first_flag)
  );

  event_flag a_second_cell (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .set_event   (a_second_set),
    .clear_event (a_data_read),
    .flag        (a_second_flag)
  );

  event_flag b_first_cell (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .set_event   (b_first_set),
    .clear_event (b_data_read),
    .flag        (b_first_flag)
  );

  event_flag b_second_cell (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .set_event   (b_second_set),
    .clear_event (b_data_read),
    .flag        (b_second_flag)
  );

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  // Enables gate the flag, not the setting, so a late enable
  // still raises a pending request
  wire a_request = (a_first_flag & port_a_control[`FIRST_ENABLE_BIT]) |
                   (a_second_flag & port_a_control[`AUX_CTRL3_BIT] &
                    ~port_a_control[`AUX_OUTPUT_BIT]);
  wire b_request = (b_first_flag & port_b_control[`FIRST_ENABLE_BIT]) |
                   (b_second_flag & port_b_control[`AUX_CTRL3_BIT] &
                    ~port_b_control[`AUX_OUTPUT_BIT]);

  // Open drain: only ever pulls low
  assign a_int_request_n_out = 1'b0;
  assign a_int_request_n_oe  = a_request;
  assign b_int_request_n_out = 1'b0;
  assign b_int_request_n_oe  = b_request;

  // ************************************************************
  // Second line output modes
  // ************************************************************
  aux_mode_type a_mode;
  aux_mode_type b_mode;

  assign a_mode = ~port_a_control[`AUX_OUTPUT_BIT] ? aux_input :
                  port_a_control[`AUX_CTRL4_BIT]   ? aux_level :
                  port_a_control[`AUX_CTRL3_BIT]   ? aux_pulse :
                                                     aux_handshake;
  assign b_mode = ~port_b_control[`AUX_OUTPUT_BIT] ? aux_input :
                  port_b_control[`AUX_CTRL4_BIT]   ? aux_level :
                  port_b_control[`AUX_CTRL3_BIT]   ? aux_pulse :
                                                     aux_handshake;

  logic a_strobe_level;
  logic b_strobe_level;
  logic b_write_pending;
  logic b_deselect_seen;

  wire a_raise = ((a_mode == aux_handshake) & a_first_set) |
                 ((a_mode == aux_pulse) & end_deselected);
  wire b_raise = ((b_mode == aux_handshake) & b_first_set) |
                 ((b_mode == aux_pulse) & enable_rise & b_deselect_seen);
  wire b_drop  = enable_rise & b_write_pending;

  // Port A: dropped at the fall of the reading enable pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      a_strobe_level <= 1'b0;
    end else if (a_raise) begin
      a_strobe_level <= 1'b1;
    end else if (a_data_read) begin
      a_strobe_level <= 1'b0;
    end
  end

  // Port B: a write marks the next enable rise for the drop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      b_write_pending <= 1'b0;
      b_deselect_seen <= 1'b0;
      b_strobe_level  <= 1'b0;
    end else begin
      if (b_data_write_strobe) begin
        b_write_pending <= 1'b1;
      end else if (enable_rise) begin
        b_write_pending <= 1'b0;
      end
      if (end_deselected) begin
        b_deselect_seen <= 1'b1;
      end else if (enable_rise) begin
        b_deselect_seen <= 1'b0;
      end
      if (b_raise) begin
        b_strobe_level <= 1'b1;
      end else if (b_drop) begin
        b_strobe_level <= 1'b0;
      end
    end
  end

  // Level mode follows the stored bit, so it moves only on a write
  assign a_aux_line_out = (a_mode == aux_level) ?
                          port_a_control[`AUX_CTRL3_BIT] : a_strobe_level;
  assign b_aux_line_out = (b_mode == aux_level) ?
                          port_b_control[`AUX_CTRL3_BIT] : b_strobe_level;
  assign a_aux_line_oe  = (a_mode != aux_input);
  assign b_aux_line_oe  = (b_mode != aux_input);

  // ************************************************************
  // Read data path
  // ************************************************************
  wire [`DATA_WIDTH-1:0] a_ctrl_word = {a_first_flag, a_second_flag,
                                        port_a_control};
  wire [`DATA_WIDTH-1:0] b_ctrl_word = {b_first_flag, b_second_flag,
                                        port_b_control};
  wire [`DATA_WIDTH-1:0] a_port_word = a_data_view ?
                                       a_data_rdata : a_direction_rdata;
  wire [`DATA_WIDTH-1:0] b_port_word = b_data_view ?
                                       b_data_rdata : b_direction_rdata;

  logic [`DATA_WIDTH-1:0] next_read_data;

  always_comb begin
    unique case (reg_select)
      `SEL_A_DATA: next_read_data = a_port_word;
      `SEL_A_CTRL: next_read_data = a_ctrl_word;
      `SEL_B_DATA: next_read_data = b_port_word;
      `SEL_B_CTRL: next_read_data = b_ctrl_word;
    endcase
  end

  // Captured at the enable rise; flags clear only at the fall, so
  // the read still shows them
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_read_data <= `DATA_RESET;
      bus_read_oe   <= 1'b0;
    end else if (enable_rise & selected & is_read) begin
      bus_read_data <= next_read_data;
      bus_read_oe   <= 1'b1;
    end else if (enable_fall) begin
      bus_read_oe   <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> common/port_ctrl_defs.svh
// Bit positions, select codes and reset values of the port control logic
`ifndef PORT_CTRL_DEFS_SVH
`define PORT_CTRL_DEFS_SVH

`define DATA_WIDTH        8
`define CTRL_RW_WIDTH     6
`define CTRL_RESET        6'h00
`define DATA_RESET        8'h00

// Control word fields
`define FIRST_ENABLE_BIT  0
`define FIRST_EDGE_BIT    1
`define DIR_ACCESS_BIT    2
`define AUX_CTRL3_BIT     3
`define AUX_CTRL4_BIT     4
`define AUX_OUTPUT_BIT    5
`define SECOND_FLAG_BIT   6
`define FIRST_FLAG_BIT    7

// Register select codes {reg_select_high, reg_select_low}
`define SEL_A_DATA        2'h0
`define SEL_A_CTRL        2'h1
`define SEL_B_DATA        2'h2
`define SEL_B_CTRL        2'h3

// Synchronised pin vector widths
`define BUS_PIN_WIDTH     13
`define LINE_PIN_WIDTH    4

`endif

// >>> common/port_ctrl_pkg.sv
// Types shared by the port control logic
package port_ctrl_pkg;

  typedef enum logic [1:0] {
    aux_input,
    aux_handshake,
    aux_pulse,
    aux_level
  } aux_mode_type;

endpackage

// >>> core/pin_sync.sv
// Two-flop synchroniser with edge detection for a group of pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] last;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage_one <= '0;
      stage_two <= '0;
      last      <= '0;
    end else begin
      stage_one <= pin_in;
      stage_two <= stage_one;
      last      <= stage_two;
    end
  end

  assign level = stage_two;
  assign rise  = stage_two & ~last;
  assign fall  = ~stage_two & last;

endmodule

`default_nettype wire

// >>> core/event_flag.sv
// Sticky flag where a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none

module event_flag (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic set_event,
  input  wire logic clear_event,
  output logic      flag
);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (clear_event) begin
      flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> tb/port_ctrl_properties.sv
// Bus timing, strobe decode and request assertions for the port control logic
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bus_enable_pulse,
  input wire logic chip_select,
  input wire logic read_not_write,
  input wire logic reg_select_low,
  input wire logic reg_select_high,
  input wire logic bus_read_oe,
  input wire logic a_aux_line_oe,
  input wire logic a_int_request_n_out,
  input wire logic a_int_request_n_oe,
  input wire logic b_int_request_n_oe,
  input wire logic a_data_read_strobe,
  input wire logic a_data_write_strobe,
  input wire logic b_data_write_strobe
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  reset_clears_a: assert property (disable iff (1'b0) reset |=> !bus_read_oe && !a_int_request_n_oe && !a_aux_line_oe)
    else $error("outputs not cleared by reset");
  read_oe_rise_a: assert property ($rose(bus_enable_pulse) && chip_select && read_not_write |=> ##[1:3] bus_read_oe)
    else $error("read output enable late");
  read_oe_drop_a: assert property ($fell(bus_enable_pulse) |-> ##[1:4] !bus_read_oe)
    else $error("read output enable held");
  clear_strobe_single_a: assert property (a_data_read_strobe |=> !a_data_read_strobe)
    else $error("read strobe longer than one cycle");
  read_strobe_decode_a: assert property (a_data_read_strobe |-> chip_select && read_not_write && !reg_select_high && !reg_select_low)
    else $error("read strobe without data read");
  write_strobe_a_a: assert property (a_data_write_strobe |-> !bus_enable_pulse && !read_not_write && !reg_select_high && !reg_select_low)
    else $error("port a write strobe misdecoded");
  write_strobe_b_a: assert property (b_data_write_strobe |-> !read_not_write && reg_select_high && !reg_select_low)
    else $error("port b write strobe misdecoded");
  open_drain_a: assert property (!a_int_request_n_out)
    else $error("request output driven high");
  request_release_a: assert property ($fell(b_int_request_n_oe) |-> !bus_enable_pulse && chip_select)
    else $error("request released outside a bus cycle");
  aux_drive_change_a: assert property ($changed(a_aux_line_oe) |-> !bus_enable_pulse && !read_not_write)
    else $error("line drive changed without write");
endmodule
bind port_control_line_interrupt_logic port_ctrl_properties i_port_ctrl_properties (.*);
`default_nettype wire

// >>> tb/peripheral_model.sv
// Peripheral side model: port registers behind the strobes and line levels
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] port_write_data,
  input  wire logic       a_data_write_strobe,
  input  wire logic       a_direction_write_strobe,
  input  wire logic       b_data_write_strobe,
  input  wire logic       b_direction_write_strobe,
  input  wire logic [3:0] line_level,
  input  wire logic       a_aux_line_out,
  input  wire logic       a_aux_line_oe,
  input  wire logic       b_aux_line_out,
  input  wire logic       b_aux_line_oe,
  output logic      [7:0] a_data_rdata,
  output logic      [7:0] a_direction_rdata,
  output logic      [7:0] b_data_rdata,
  output logic      [7:0] b_direction_rdata,
  output logic            a_edge_input,
  output logic            b_edge_input,
  output logic            a_aux_line_in,
  output logic            b_aux_line_in
);
  // ****************************************
  // Port registers
  // ****************************************
  logic [3:0] wr_late;
  // Written byte only valid one clock after its strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_late <= 4'h0;
      a_data_rdata <= 8'h00;
      a_direction_rdata <= 8'h00;
      b_data_rdata <= 8'h00;
      b_direction_rdata <= 8'h00;
    end else begin
      wr_late <= {b_direction_write_strobe, b_data_write_strobe, a_direction_write_strobe, a_data_write_strobe};
      if (wr_late[0]) a_data_rdata <= port_write_data;
      if (wr_late[1]) a_direction_rdata <= port_write_data;
      if (wr_late[2]) b_data_rdata <= port_write_data;
      if (wr_late[3]) b_direction_rdata <= port_write_data;
    end
  end
  assign a_edge_input = line_level[0];
  assign b_edge_input = line_level[1];
  // A driven line reads back its own level
  assign a_aux_line_in = a_aux_line_oe ? a_aux_line_out : line_level[2];
  assign b_aux_line_in = b_aux_line_oe ? b_aux_line_out : line_level[3];
endmodule
`default_nettype wire

// >>> tb/port_control_line_interrupt_logic_tb.sv
// Self-checking bench for the port control line and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defs.svh"
module port_control_line_interrupt_logic_tb;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       bus_enable_pulse = 1'b0;
  logic       chip_select = 1'b0;
  logic       read_not_write = 1'b1;
  logic       reg_select_low = 1'b0;
  logic       reg_select_high = 1'b0;
  logic [7:0] bus_write_data = 8'h00;
  logic [3:0] line_level = 4'h0;
  logic [7:0] bus_read_data, a_data_rdata, a_direction_rdata, b_data_rdata, b_direction_rdata, port_write_data;
  logic       bus_read_oe, a_edge_input, b_edge_input, a_aux_line_in, a_aux_line_out, a_aux_line_oe;
  logic       b_aux_line_in, b_aux_line_out, b_aux_line_oe, a_int_request_n_out, a_int_request_n_oe;
  logic       b_int_request_n_out, b_int_request_n_oe, a_data_read_strobe, a_data_write_strobe;
  logic       a_direction_write_strobe, b_data_read_strobe, b_data_write_strobe, b_direction_write_strobe;
  logic [7:0] exp_q[$];
  logic [7:0] va, vb, vd, base, en, fl;
  logic [1:0] sc;
  logic [1:0] li;
  logic       oe_seen = 1'b0;
  logic [31:0] seed = 32'h00000029;
  int         n_mismatch = 0;
  int         total_checks = 0;

  port_control_line_interrupt_logic i_port_control_line_interrupt_logic (.*);
  peripheral_model i_peripheral_model (.*);

  initial forever #20 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] irq(input logic p);
    return {7'h00, p ? b_int_request_n_oe : a_int_request_n_oe};
  endfunction
  function automatic logic [7:0] aux(input logic p);
    return {7'h00, p ? b_aux_line_out : a_aux_line_out};
  endfunction
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Pin held well past the two-flop synchroniser in each phase
  task automatic bus(input logic rnw, input logic [1:0] sel, input logic [7:0] d, input logic cs);
    @(posedge ref_clk);
    chip_select <= cs;
    read_not_write <= rnw;
    {reg_select_high, reg_select_low} <= sel;
    bus_write_data <= d;
    bus_enable_pulse <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus_enable_pulse <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    bus(1'b0, sel, d, 1'b1);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b1, sel, 8'h00, 1'b1);
  endtask
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (bus_read_oe === 1'b1 && oe_seen !== 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] unexpected_read expected none seen %h", bus_read_data);
      end else begin
        cmp("bus_read_data", exp_q.pop_front(), bus_read_data);
      end
    end
    oe_seen = bus_read_oe;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`SEL_A_CTRL, 8'h00);
    rd(`SEL_B_CTRL, 8'h00);
    cmp("b_request", 8'h00, irq(1'b1));
    cmp("b_request_out", 8'h00, {7'h00, b_int_request_n_out});
    wr(`SEL_A_CTRL, 8'h04);
    wr(`SEL_B_CTRL, 8'h04);
    va = xs();
    vb = xs();
    wr(`SEL_A_DATA, va);
    wr(`SEL_B_DATA, vb);
    // Both lines of both ports, both edge polarities
    for (int k = 0; k < 8; k++) begin
      base = k[2] ? {3'h0, k[1], 4'h4} : {6'h01, k[1], 1'b0};
      en = k[2] ? 8'h08 : 8'h01;
      fl = k[2] ? 8'h40 : 8'h80;
      li = {k[2], k[0]};
      sc = k[0] ? `SEL_B_CTRL : `SEL_A_CTRL;
      wr(sc, base);
      line_level[li] <= !k[1];
      repeat (6) @(posedge ref_clk);
      wr(sc, base);
      line_level[li] <= k[1];
      repeat (6) @(posedge ref_clk);
      rd(sc, fl | base);
      cmp("request_masked", 8'h00, irq(k[0]));
      wr(sc, base | en);
      cmp("request_late", 8'h01, irq(k[0]));
      rd(sc - 2'h1, k[0] ? vb : va);
      rd(sc, base | en);
      cmp("request_clear", 8'h00, irq(k[0]));
    end
    for (int p = 0; p < 2; p++) begin
      sc = p ? `SEL_B_CTRL : `SEL_A_CTRL;
      wr(sc, 8'hFF);
      rd(sc, 8'h3F);
      cmp("aux_level_high", 8'h01, aux(p));
      wr(sc, 8'h34);
      cmp("aux_level_low", 8'h00, aux(p));
    end
    wr(`SEL_A_CTRL, 8'h24);
    cmp("a_aux_drive", 8'h01, {7'h00, a_aux_line_oe});
    line_level[0] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp("a_aux_handshake", 8'h01, aux(1'b0));
    rd(`SEL_A_DATA, va);
    cmp("a_aux_read", 8'h00, aux(1'b0));
    wr(`SEL_A_CTRL, 8'h2C);
    bus(1'b1, `SEL_A_DATA, 8'h00, 1'b0);
    cmp("a_aux_deselect", 8'h01, aux(1'b0));
    rd(`SEL_A_DATA, va);
    cmp("a_aux_pulse", 8'h00, aux(1'b0));
    wr(`SEL_B_CTRL, 8'h24);
    cmp("b_aux_drive", 8'h01, {7'h00, b_aux_line_oe});
    line_level[1] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp("b_aux_handshake", 8'h01, aux(1'b1));
    vb = xs();
    wr(`SEL_B_DATA, vb);
    cmp("b_aux_hold", 8'h01, aux(1'b1));
    bus(1'b1, `SEL_B_DATA, 8'h00, 1'b0);
    cmp("b_aux_write", 8'h00, aux(1'b1));
    wr(`SEL_B_CTRL, 8'h2C);
    // Deselected pulse first, so the write pulse raises the line
    bus(1'b1, `SEL_B_DATA, 8'h00, 1'b0);
    vb = xs();
    wr(`SEL_B_DATA, vb);
    cmp("b_aux_pulse_set", 8'h01, aux(1'b1));
    bus(1'b1, `SEL_B_DATA, 8'h00, 1'b0);
    cmp("b_aux_pulse_low", 8'h00, aux(1'b1));
    bus(1'b1, `SEL_B_DATA, 8'h00, 1'b0);
    cmp("b_aux_pulse_high", 8'h01, aux(1'b1));
    rd(`SEL_B_DATA, vb);
    wr(`SEL_A_CTRL, 8'h00);
    vd = xs();
    wr(`SEL_A_DATA, vd);
    rd(`SEL_A_DATA, vd);
    wr(`SEL_B_CTRL, 8'h00);
    wr(`SEL_B_DATA, vd);
    rd(`SEL_B_DATA, vd);
    wr(`SEL_A_CTRL, 8'h04);
    rd(`SEL_A_DATA, va);
    // Reset in mid-run with a driven line and live control bits
    wr(`SEL_A_CTRL, 8'h3F);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`SEL_A_CTRL, 8'h00);
    cmp("a_aux_reset", 8'h00, {7'h00, a_aux_line_oe});
    if (exp_q.size() != 0) cmp("reads_answered", 8'h00, 8'(exp_q.size()));
    results();
  end
endmodule
`default_nettype wire
